/* led_fault_cfg.svh */
// Timing constants for the LED fault supervisor
`ifndef LED_FAULT_CFG_SVH
`define LED_FAULT_CFG_SVH
`define CLK_PERIOD_NS 4
`define SHUTDOWN_DELAY_MS 16
`define SHUTDOWN_DELAY_CYC ((`SHUTDOWN_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define EXT_FAULT_SW_CYCLES 8
`define NUM_STRINGS 6
`endif

/* led_fault_pkg.sv */
// Types shared by the LED fault supervisor
package led_fault_pkg;
   typedef enum logic {CONTINUE_MODE, ALL_OUT_MODE} fault_mode_t;
   typedef struct packed {
      logic [5:0] shortAbove;
      logic [5:0] inRegulation;
      logic [5:0] noCurrent;
      logic overvoltageTrip;
      logic overvoltageLow;
      logic primaryCurrentLimit;
      logic secondaryCurrentLimit;
   } comp_flags_t;
endpackage

/* sync_two_stage.sv */
// Two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module sync_two_stage #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] next_stage1;
   logic [WIDTH-1:0] next_syncOut;
   always_comb begin
      next_stage1 = srst ? '0 : asyncIn;
      next_syncOut = srst ? '0 : stage1;
   end
   always_ff @(posedge clk) begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
   end
endmodule
`default_nettype wire

/* led_driver_fault_supervisor.sv */
// Fault supervision and shutdown sequencing for a six-string LED driver
`timescale 1ns/10ps
`default_nettype none
`include "led_fault_cfg.svh"
module led_driver_fault_supervisor
   import led_fault_pkg::*;
#(
   parameter int SHUTDOWN_CYCLES = `SHUTDOWN_DELAY_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic enablePwm,
   input wire led_fault_pkg::fault_mode_t faultMode,
   input wire led_fault_pkg::comp_flags_t compFlags,
   input wire logic swCycleTick,
   input wire logic softStartDone,
   input wire logic faultLineIn,
   output logic faultLineOut,
   output logic faultLineOe,
   output logic [5:0] stringEnable,
   output logic boostEnable,
   output logic endOnTime,
   output logic softStartRequest,
   output logic sleepActive
);
   typedef enum logic [1:0] {SLEEP, SOFT_START, RUNNING, LATCHED_OFF} sup_state_t;

   localparam int SLEEP_W = $clog2(SHUTDOWN_CYCLES + 1);

   // Synchronised copies of the comparator flags, enablePwm and faultLineIn
   comp_flags_t flags;
   logic enSync;
   logic lineSync;
   sync_two_stage #(.WIDTH($bits(comp_flags_t) + 2)) u_sync (
      .clk(clk),
      .srst(srst),
      .asyncIn({compFlags, enablePwm, faultLineIn}),
      .syncOut({flags, enSync, lineSync})
   );

   sup_state_t state;
   sup_state_t next_state;
   logic [SLEEP_W-1:0] lowCount;
   logic [SLEEP_W-1:0] next_lowCount;
   logic [3:0] extCount;
   logic [3:0] next_extCount;
   logic [5:0] dropped;
   logic [5:0] next_dropped;
   logic faultLatch;
   logic next_faultLatch;
   logic ovHalt;
   logic next_ovHalt;
   logic next_faultLineOe;
   logic [5:0] next_stringEnable;
   logic next_boostEnable;
   logic next_endOnTime;
   logic next_softStartRequest;
   logic next_sleepActive;

   logic allOut;
   logic shortArmed;
   logic [5:0] shortHit;
   logic anyShort;
   logic openHit;
   logic extFault;

   always_comb begin
      allOut = (faultMode == ALL_OUT_MODE);
      shortArmed = |(flags.inRegulation & ~dropped);
      shortHit = shortArmed ? (flags.shortAbove & ~dropped) : 6'h00;
      anyShort = |shortHit;
      openHit = |(flags.noCurrent & ~dropped);
      // External fault only counts when this device is not the one pulling
      extFault = allOut && (extCount > 4'(`EXT_FAULT_SW_CYCLES));
   end

   always_comb begin
      next_state = state;
      next_lowCount = lowCount;
      next_extCount = extCount;
      next_dropped = dropped;
      next_faultLatch = faultLatch;
      next_ovHalt = ovHalt;
      if (enSync) begin
         next_lowCount = '0;
      end else if (lowCount < SLEEP_W'(SHUTDOWN_CYCLES)) begin
         next_lowCount = lowCount + SLEEP_W'(1);
      end
      if (!allOut || lineSync || faultLineOe) begin
         next_extCount = 4'h0;
      end else if (swCycleTick && extCount != 4'hf) begin
         next_extCount = extCount + 4'h1;
      end
      // Overvoltage halts switching with hysteresis; it latches only in soft start while a live string is out of regulation
      if (flags.overvoltageTrip) begin
         next_ovHalt = 1'b1;
      end else if (flags.overvoltageLow) begin
         next_ovHalt = 1'b0;
      end
      case (state)
         SLEEP: begin
            if (enSync) begin
               next_dropped = 6'h00;
               next_faultLatch = 1'b0;
               next_ovHalt = 1'b0;
               next_extCount = 4'h0;
               next_state = SOFT_START;
            end
         end
         SOFT_START, RUNNING: begin
            if (state == SOFT_START && softStartDone) begin
               next_state = RUNNING;
            end
            if (flags.secondaryCurrentLimit) begin
               next_faultLatch = 1'b1;
               next_state = LATCHED_OFF;
            end else if (extFault) begin
               next_state = LATCHED_OFF;
            end else if (allOut && anyShort) begin
               next_faultLatch = 1'b1;
               next_state = LATCHED_OFF;
            end else if (allOut && state == SOFT_START && flags.overvoltageTrip &&
                         |(~flags.inRegulation & ~dropped)) begin
               next_faultLatch = 1'b1;
               next_state = LATCHED_OFF;
            end else if (allOut && state == RUNNING && openHit) begin
               next_faultLatch = 1'b1;
               next_state = LATCHED_OFF;
            end else if (!allOut) begin
               if (anyShort) begin
                  next_dropped = dropped | shortHit;
                  next_faultLatch = 1'b1;
               end
               if (flags.overvoltageTrip && state == SOFT_START &&
                   |(~flags.inRegulation & ~dropped)) begin
                  next_dropped = next_dropped | ~flags.inRegulation;
                  next_faultLatch = 1'b1;
               end else if (flags.overvoltageTrip && state == RUNNING && openHit) begin
                  next_dropped = next_dropped | flags.noCurrent;
               end
            end
         end
         LATCHED_OFF: begin
         end
         default: begin
            next_state = SLEEP;
         end
      endcase
      // Sleep after a long low enable; also the only way out of latch-off
      if (state != SLEEP && lowCount >= SLEEP_W'(SHUTDOWN_CYCLES)) begin
         next_state = SLEEP;
      end
   end

   always_comb begin
      next_stringEnable = 6'h00;
      next_boostEnable = 1'b0;
      next_endOnTime = flags.primaryCurrentLimit;
      next_softStartRequest = (next_state == SOFT_START);
      next_sleepActive = (next_state == SLEEP);
      if (next_state == SOFT_START || next_state == RUNNING) begin
         next_stringEnable = ~next_dropped;
         // Current limit gating is registered like endOnTime; both follow the synchronised flags one cycle later
         next_boostEnable = ~next_ovHalt && ~flags.secondaryCurrentLimit;
      end
      next_faultLineOe = next_faultLatch;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= SLEEP;
         lowCount <= '0;
         extCount <= 4'h0;
         dropped <= 6'h00;
         faultLatch <= 1'b0;
         ovHalt <= 1'b0;
         faultLineOe <= 1'b0;
         stringEnable <= 6'h00;
         boostEnable <= 1'b0;
         endOnTime <= 1'b0;
         softStartRequest <= 1'b0;
         sleepActive <= 1'b1;
      end else begin
         state <= next_state;
         lowCount <= next_lowCount;
         extCount <= next_extCount;
         dropped <= next_dropped;
         faultLatch <= next_faultLatch;
         ovHalt <= next_ovHalt;
         faultLineOe <= next_faultLineOe;
         stringEnable <= next_stringEnable;
         boostEnable <= next_boostEnable;
         endOnTime <= next_endOnTime;
         softStartRequest <= next_softStartRequest;
         sleepActive <= next_sleepActive;
      end
   end

   // Open drain: the output level is always low, only the enable moves
   always_ff @(posedge clk) begin
      faultLineOut <= 1'b0;
   end
endmodule
`default_nettype wire

/* fault_wire_model.sv */
// Wired-AND fault line shared with a peer driver
`timescale 1ns/10ps
`default_nettype none
module fault_wire_model (
   input wire logic faultLineOe,
   input wire logic peerLow,
   output logic faultLineIn
);
   // Pull-up wins once every party lets go
   assign faultLineIn = !(faultLineOe || peerLow);
endmodule
`default_nettype wire

/* led_fault_props.sv */
// Checker for the LED fault supervisor ports
`timescale 1ns/10ps
`default_nettype none
module led_fault_props
   import led_fault_pkg::*;
#(
   parameter int SHUTDOWN_CYCLES = 20
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic enablePwm,
   input wire led_fault_pkg::comp_flags_t compFlags,
   input wire logic faultLineOut,
   input wire logic faultLineOe,
   input wire logic [5:0] stringEnable,
   input wire logic boostEnable,
   input wire logic endOnTime,
   input wire logic softStartRequest,
   input wire logic sleepActive
);
   int lowCount;
   int next_lowCount;
   always_comb begin
      next_lowCount = enablePwm ? 0 : lowCount + 1;
   end
   always_ff @(posedge clk) begin
      lowCount <= srst ? 0 : next_lowCount;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   drain_only_a: assert property (faultLineOut == 1'b0) else $error("line driven high");
   sleep_entry_a: assert property (lowCount > SHUTDOWN_CYCLES + 4 |-> sleepActive)
      else $error("no sleep");
   sleep_dark_a: assert property (sleepActive |-> stringEnable == 6'h00 && !boostEnable)
      else $error("lit in sleep");
   wake_clear_a: assert property ($fell(sleepActive) |-> ##[1:3] !faultLineOe)
      else $error("latch kept");
   soft_awake_a: assert property (softStartRequest |-> !sleepActive)
      else $error("soft start asleep");
   string_restart_a: assert property (stringEnable != 6'h00 && $past(stringEnable) == 6'h00
      |-> softStartRequest) else $error("no soft start");
   ontime_end_a: assert property ($rose(compFlags.primaryCurrentLimit) && boostEnable
      |-> ##[2:4] endOnTime) else $error("on-time kept");
   second_limit_a: assert property ($rose(compFlags.secondaryCurrentLimit)
      |-> ##4 (!boostEnable && stringEnable == 6'h00)) else $error("no latch off");
endmodule
bind led_driver_fault_supervisor led_fault_props #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES)) props (
   .clk, .srst, .enablePwm, .compFlags, .faultLineOut, .faultLineOe, .stringEnable,
   .boostEnable, .endOnTime, .softStartRequest, .sleepActive);
`default_nettype wire

/* led_driver_fault_supervisor_test.sv */
// Self-checking bench for the LED fault supervisor
`timescale 1ns/10ps
`default_nettype none
module led_driver_fault_supervisor_test;
   import led_fault_pkg::*;
   localparam int SHUT = 20;
   logic clk, srst, enablePwm, swCycleTick, softStartDone, faultLineIn, peerLow;
   fault_mode_t faultMode;
   comp_flags_t compFlags;
   logic faultLineOut, faultLineOe, boostEnable, endOnTime, softStartRequest, sleepActive;
   logic [5:0] stringEnable, b, m;
   int nMismatch = 0;
   int comparisons = 0;
   led_driver_fault_supervisor #(.SHUTDOWN_CYCLES(SHUT)) dut (.clk, .srst, .enablePwm,
      .faultMode, .compFlags, .swCycleTick, .softStartDone, .faultLineIn, .faultLineOut,
      .faultLineOe, .stringEnable, .boostEnable, .endOnTime, .softStartRequest, .sleepActive);
   fault_wire_model wire0 (.faultLineOe, .peerLow, .faultLineIn);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
      if (nMismatch == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         nMismatch++;
         $display("BAD %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Flags held well past the synchroniser and output register
   task automatic apply(input comp_flags_t f, input logic done);
      @(posedge clk);
      compFlags <= f;
      softStartDone <= done;
      step(6);
   endtask
   task automatic wake();
      @(posedge clk);
      enablePwm <= 1'b1;
      step(6);
      check(sleepActive, 0);
      check(softStartRequest, 1);
      check(stringEnable, 8'h3f);
      check(faultLineOe, 0);
      check(faultLineOut, 0);
   endtask
   task automatic sleep();
      apply('0, 1'b0);
      enablePwm <= 1'b0;
      step(SHUT + 8);
      check(sleepActive, 1);
      check(stringEnable, 0);
   endtask
   task automatic restart(input fault_mode_t mode);
      @(posedge clk);
      srst <= 1'b1;
      faultMode <= mode;
      step(20);
      srst <= 1'b0;
      wake();
   endtask
   initial begin
      srst = 1'b1;
      enablePwm = 1'b0;
      faultMode = CONTINUE_MODE;
      compFlags = '0;
      swCycleTick = 1'b0;
      softStartDone = 1'b0;
      peerLow = 1'b0;
      void'($urandom(78));
      b = 6'h01 << $urandom_range(5, 1);
      m = 6'($urandom_range(62, 1));
      restart(CONTINUE_MODE);
      apply('{shortAbove: b, default: '0}, 1'b1);
      check(stringEnable, 8'h3f);
      apply('{shortAbove: b, inRegulation: 6'h01, default: '0}, 1'b1);
      check(stringEnable, 6'h3f & ~b);
      check(faultLineOe, 1);
      sleep();
      check(faultLineOe, 1);
      wake();
      apply('{overvoltageTrip: 1'b1, default: '0}, 1'b1);
      check({boostEnable, faultLineOe}, 0);
      apply('{overvoltageTrip: 1'b1, noCurrent: b, default: '0}, 1'b1);
      check(stringEnable, 6'h3f & ~b);
      apply('{overvoltageLow: 1'b1, default: '0}, 1'b1);
      check(boostEnable, 1);
      sleep();
      wake();
      apply('{overvoltageTrip: 1'b1, inRegulation: m, default: '0}, 1'b0);
      check({boostEnable, faultLineOe, stringEnable}, {2'b01, m});
      apply('{overvoltageLow: 1'b1, inRegulation: m, default: '0}, 1'b0);
      check(boostEnable, 1);
      apply('{primaryCurrentLimit: 1'b1, default: '0}, 1'b1);
      check(endOnTime, 1);
      apply('{secondaryCurrentLimit: 1'b1, default: '0}, 1'b1);
      check({boostEnable, stringEnable}, 0);
      sleep();
      restart(ALL_OUT_MODE);
      apply('{shortAbove: b, inRegulation: 6'h01, default: '0}, 1'b1);
      check({faultLineOe, stringEnable}, 8'h40);
      sleep();
      wake();
      apply('{overvoltageTrip: 1'b1, inRegulation: m, default: '0}, 1'b0);
      check({boostEnable, faultLineOe, stringEnable}, 8'h40);
      sleep();
      wake();
      apply('{overvoltageTrip: 1'b1, noCurrent: b, default: '0}, 1'b1);
      check(stringEnable, 0);
      sleep();
      wake();
      peerLow <= 1'b1;
      for (int i = 1; i <= 9; i++) begin
         step(3);
         swCycleTick <= 1'b1;
         @(posedge clk);
         swCycleTick <= 1'b0;
         step(3);
         check(stringEnable, i > 8 ? 8'h00 : 8'h3f);
      end
      report_and_stop();
   end
   initial begin
      step(6000);
      nMismatch++;
      report_and_stop();
   end
endmodule
`default_nettype wire
